/* converter_id_spi_regs.v */
// Serial register bank: identity, version, interface configuration and
// analog control registers reached over a 4-wire serial port.
// Assumes the serial clock runs well below a quarter of i_clk_sys, since
// every serial input passes a two-stage synchroniser before it is used.

`include "converter_regs_defs.vh"

module converter_id_spi_regs #(
	parameter [15:0] PART_IDENTITY   = 16'h5A3C, // Value is arbitrary.
	parameter [7:0]  SILICON_VERSION = 8'h3C,    // Value is arbitrary.
	parameter [15:0] MAKER_IDENTITY  = 16'h7E21  // Value is arbitrary.
) (
	// Clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rst_n,
	// Serial port
	input  wire        i_spi_sclk,
	input  wire        i_spi_cs_n,
	input  wire        i_spi_sdi,
	output reg         o_spi_sdo,
	output reg         o_spi_sdo_oe,
	// Analog status
	input  wire [23:0] i_alignment_edge_position,
	// Analog controls
	output reg  [7:0]  o_clock_control_a,
	output reg  [7:0]  o_clock_control_b,
	output reg  [15:0] o_input_a_full_scale,
	output reg  [15:0] o_input_b_full_scale,
	output reg  [7:0]  o_reference_bypass,
	output reg  [7:0]  o_timestamp_input_control
);

	// ------------------------------------------------------------------
	// Frame states
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HDR  = 3'b010;
	localparam [2:0] ST_DATA = 3'b100;

	reg        sclk_meta;
	reg        sclk_sync;
	reg        sclk_prev;
	reg        cs_n_meta;
	reg        cs_n_sync;
	reg        sdi_meta;
	reg        sdi_sync;
	reg [23:0] align_meta;
	reg [23:0] align_pos;
	reg [2:0]  state;
	reg [4:0]  hdr_cnt;
	reg [14:0] hdr_shift;
	reg [2:0]  data_cnt;
	reg [6:0]  wr_shift;
	reg [7:0]  rd_shift;
	reg        is_read;
	reg [14:0] addr;
	reg        dir_up;
	reg [7:0]  user_if_config;

	wire        sclk_rise = sclk_sync & ~sclk_prev;
	wire        sclk_fall = ~sclk_sync & sclk_prev;
	wire [14:0] hdr_addr  = {hdr_shift[13:0], sdi_sync};
	wire        byte_end  = (state == ST_DATA) && sclk_rise &&
		(data_cnt == `DATA_LAST_BIT) && !cs_n_sync;
	wire        wr_strobe = byte_end && !is_read;
	wire [7:0]  wr_byte   = {wr_shift, sdi_sync};

	// ------------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------------
	function [7:0] read_byte;
		input [14:0] a;
		begin
			case (a)
				`ADDR_CONFIG_A:       read_byte = {2'b00, dir_up, 1'b1, 4'h0};
				`ADDR_CHIP_TYPE:      read_byte = `CHIP_TYPE_VALUE;
				`ADDR_PART_ID_LO:     read_byte = PART_IDENTITY[7:0];
				`ADDR_PART_ID_HI:     read_byte = PART_IDENTITY[15:8];
				`ADDR_VERSION:        read_byte = SILICON_VERSION;
				`ADDR_MAKER_ID_LO:    read_byte = MAKER_IDENTITY[7:0];
				`ADDR_MAKER_ID_HI:    read_byte = MAKER_IDENTITY[15:8];
				`ADDR_USER_IF_CONFIG: read_byte = user_if_config;
				`ADDR_CLOCK_CTRL_A:   read_byte = o_clock_control_a;
				`ADDR_CLOCK_CTRL_B:   read_byte = o_clock_control_b;
				`ADDR_ALIGN_POS_0:    read_byte = align_pos[7:0];
				`ADDR_ALIGN_POS_1:    read_byte = align_pos[15:8];
				`ADDR_ALIGN_POS_2:    read_byte = align_pos[23:16];
				`ADDR_FS_A_LO:        read_byte = o_input_a_full_scale[7:0];
				`ADDR_FS_A_HI:        read_byte = o_input_a_full_scale[15:8];
				`ADDR_FS_B_LO:        read_byte = o_input_b_full_scale[7:0];
				`ADDR_FS_B_HI:        read_byte = o_input_b_full_scale[15:8];
				`ADDR_REF_BYPASS:     read_byte = o_reference_bypass;
				`ADDR_TIMESTAMP_CTRL: read_byte = o_timestamp_input_control;
				default:              read_byte = 8'h00;
			endcase
		end
	endfunction

	function [14:0] step_addr;
		input [14:0] a;
		begin
			if (user_if_config[`UIC_HOLD_BIT]) begin
				step_addr = a;
			end else if (dir_up) begin
				step_addr = a + 15'h0001;
			end else begin
				step_addr = a - 15'h0001;
			end
		end
	endfunction

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	// The position bus changes only while software is not reading it, so
	// a plain two-stage bus synchroniser is accepted here.
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_meta  <= 1'b0;
			sclk_sync  <= 1'b0;
			sclk_prev  <= 1'b0;
			cs_n_meta  <= 1'b1;
			cs_n_sync  <= 1'b1;
			sdi_meta   <= 1'b0;
			sdi_sync   <= 1'b0;
			align_meta <= 24'h000000;
			align_pos  <= 24'h000000;
		end else begin
			sclk_meta  <= i_spi_sclk;
			sclk_sync  <= sclk_meta;
			sclk_prev  <= sclk_sync;
			cs_n_meta  <= i_spi_cs_n;
			cs_n_sync  <= cs_n_meta;
			sdi_meta   <= i_spi_sdi;
			sdi_sync   <= sdi_meta;
			align_meta <= i_alignment_edge_position;
			align_pos  <= align_meta;
		end
	end

	// ------------------------------------------------------------------
	// Serial frame engine
	// ------------------------------------------------------------------
	// Input is taken on rising clock edges and output moves on falling
	// edges, so a read byte is loaded at the rising edge that ends the
	// previous header or byte.
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state        <= ST_IDLE;
			hdr_cnt      <= 5'h00;
			hdr_shift    <= 15'h0000;
			data_cnt     <= 3'h0;
			wr_shift     <= 7'h00;
			rd_shift     <= 8'h00;
			is_read      <= 1'b0;
			addr         <= 15'h0000;
			o_spi_sdo    <= 1'b0;
			o_spi_sdo_oe <= 1'b0;
		end else if (cs_n_sync) begin
			state        <= ST_IDLE;
			hdr_cnt      <= 5'h00;
			data_cnt     <= 3'h0;
			o_spi_sdo    <= 1'b0;
			o_spi_sdo_oe <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					state <= ST_HDR;
				end
				ST_HDR: begin
					if (sclk_rise) begin
						hdr_shift <= hdr_addr;
						hdr_cnt   <= hdr_cnt + 5'h01;
						if (hdr_cnt == `HDR_LAST_BIT) begin
							addr         <= hdr_addr;
							is_read      <= hdr_shift[14];
							rd_shift     <= read_byte(hdr_addr);
							o_spi_sdo_oe <= hdr_shift[14];
							data_cnt     <= 3'h0;
							state        <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (sclk_rise) begin
						wr_shift <= wr_byte[6:0];
						data_cnt <= data_cnt + 3'h1;
						if (data_cnt == `DATA_LAST_BIT) begin
							addr     <= step_addr(addr);
							rd_shift <= read_byte(step_addr(addr));
						end
					end else if (sclk_fall && is_read) begin
						o_spi_sdo <= rd_shift[7];
						rd_shift  <= {rd_shift[6:0], 1'b0};
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------------
	// Identity, version, type and position addresses have no case here,
	// so a write to them is dropped.
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dir_up                    <= `RST_DIR_UP;
			user_if_config            <= `RST_USER_IF_CONFIG;
			o_clock_control_a         <= `RST_CLOCK_CTRL_A;
			o_clock_control_b         <= `RST_CLOCK_CTRL_B;
			o_input_a_full_scale      <= `RST_FULL_SCALE;
			o_input_b_full_scale      <= `RST_FULL_SCALE;
			o_reference_bypass        <= `RST_REF_BYPASS;
			o_timestamp_input_control <= `RST_TIMESTAMP_CTRL;
		end else if (wr_strobe) begin
			case (addr)
				`ADDR_CONFIG_A: begin
					dir_up <= wr_byte[`CFG_A_DIR_UP_BIT];
				end
				`ADDR_USER_IF_CONFIG: begin
					user_if_config <= wr_byte;
				end
				`ADDR_CLOCK_CTRL_A: begin
					o_clock_control_a <= wr_byte;
				end
				`ADDR_CLOCK_CTRL_B: begin
					o_clock_control_b <= wr_byte;
				end
				`ADDR_FS_A_LO: begin
					o_input_a_full_scale[7:0] <= wr_byte;
				end
				`ADDR_FS_A_HI: begin
					o_input_a_full_scale[15:8] <= wr_byte;
				end
				`ADDR_FS_B_LO: begin
					o_input_b_full_scale[7:0] <= wr_byte;
				end
				`ADDR_FS_B_HI: begin
					o_input_b_full_scale[15:8] <= wr_byte;
				end
				`ADDR_REF_BYPASS: begin
					o_reference_bypass <= wr_byte;
				end
				`ADDR_TIMESTAMP_CTRL: begin
					o_timestamp_input_control <= wr_byte;
				end
				default: begin
					dir_up <= dir_up;
				end
			endcase
		end
	end

endmodule // converter_id_spi_regs

/* converter_regs_defs.vh */
// Register map, field positions and reset values of the serial register bank.
// Included by the register bank only; holds definitions and nothing else.
`ifndef CONVERTER_REGS_DEFS_VH
`define CONVERTER_REGS_DEFS_VH

// ----------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------
`define ADDR_CONFIG_A        15'h0000
`define ADDR_CHIP_TYPE       15'h0003
`define ADDR_PART_ID_LO      15'h0004
`define ADDR_PART_ID_HI      15'h0005
`define ADDR_VERSION         15'h0006
`define ADDR_MAKER_ID_LO     15'h000C
`define ADDR_MAKER_ID_HI     15'h000D
`define ADDR_USER_IF_CONFIG  15'h0010
`define ADDR_CLOCK_CTRL_A    15'h0029
`define ADDR_CLOCK_CTRL_B    15'h002A
`define ADDR_ALIGN_POS_0     15'h002C
`define ADDR_ALIGN_POS_1     15'h002D
`define ADDR_ALIGN_POS_2     15'h002E
`define ADDR_FS_A_LO         15'h0030
`define ADDR_FS_A_HI         15'h0031
`define ADDR_FS_B_LO         15'h0032
`define ADDR_FS_B_HI         15'h0033
`define ADDR_REF_BYPASS      15'h0038
`define ADDR_TIMESTAMP_CTRL  15'h003B

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CFG_A_DIR_UP_BIT     5
`define CFG_A_WIRE4_BIT      4
`define UIC_HOLD_BIT         0
`define CHIP_TYPE_VALUE      8'h03
`define RST_DIR_UP           1'b1
`define RST_USER_IF_CONFIG   8'h00
`define RST_CLOCK_CTRL_A     8'h00
`define RST_CLOCK_CTRL_B     8'h20
`define RST_FULL_SCALE       16'hA000
`define RST_REF_BYPASS       8'h00
`define RST_TIMESTAMP_CTRL   8'h00

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define HDR_LAST_BIT         5'h0F
`define DATA_LAST_BIT        3'h7

`endif

/* converter_id_spi_regs_props.sv */
// Port checker for the serial register bank.
// Assumes a host whose sclk phases last at least four system clocks.
module converter_id_spi_regs_props (
	input wire        i_clk_sys,
	input wire        i_rst_n,
	input wire        i_spi_sclk,
	input wire        i_spi_cs_n,
	input wire        o_spi_sdo,
	input wire        o_spi_sdo_oe,
	input wire [7:0]  o_clock_control_a,
	input wire [7:0]  o_clock_control_b,
	input wire [15:0] o_input_a_full_scale,
	input wire [15:0] o_input_b_full_scale
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	sequence idle5;
		i_spi_cs_n [*5];
	endsequence
	sequence released;
		$rose(i_rst_n);
	endsequence
	chk_fs_reset_val: assert property (
		released |-> o_input_a_full_scale == 16'hA000
		&& o_input_b_full_scale == 16'hA000) else $error("bad fs reset");
	chk_ctrl_reset_val: assert property (
		released |-> o_clock_control_a == 8'h00
		&& o_clock_control_b == 8'h20) else $error("bad ctrl reset");
	chk_idle_quiet: assert property (
		idle5 |-> !o_spi_sdo_oe && !o_spi_sdo) else $error("sdo out of frame");
	chk_fs_idle_stable: assert property (
		idle5 |=> $stable(o_input_a_full_scale)
		&& $stable(o_input_b_full_scale)) else $error("fs moved idle");
	chk_ctrl_idle_stable: assert property (
		idle5 |=> $stable(o_clock_control_a)
		&& $stable(o_clock_control_b)) else $error("ctrl moved idle");
	chk_oe_after_header: assert property (
		$rose(o_spi_sdo_oe) |-> !i_spi_cs_n && $past(i_spi_sclk, 2))
		else $error("oe rose off header end");
	chk_oe_drop_late: assert property (
		$fell(o_spi_sdo_oe) |-> $past(i_spi_cs_n, 3))
		else $error("oe fell inside frame");
	chk_sdo_on_fall: assert property (
		o_spi_sdo_oe && $past(o_spi_sdo_oe) && $changed(o_spi_sdo)
		|-> !$past(i_spi_sclk, 3)) else $error("sdo moved off fall");
endmodule // converter_id_spi_regs_props

bind converter_id_spi_regs converter_id_spi_regs_props i_props (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_spi_sclk(i_spi_sclk),
	.i_spi_cs_n(i_spi_cs_n), .o_spi_sdo(o_spi_sdo),
	.o_spi_sdo_oe(o_spi_sdo_oe), .o_clock_control_a(o_clock_control_a),
	.o_clock_control_b(o_clock_control_b),
	.o_input_a_full_scale(o_input_a_full_scale),
	.o_input_b_full_scale(o_input_b_full_scale));

/* spi_host.sv */
// Serial host model: mode 0 frames, MSB first, six clocks a phase.
// Assumes the caller enters xfer just after a rising clock edge.
module spi_host (
	input  wire i_clk_sys,
	input  wire i_spi_sdo,
	output reg  o_spi_sclk,
	output reg  o_spi_cs_n,
	output reg  o_spi_sdi
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_spi_sclk = 1'b0;
		o_spi_cs_n = 1'b1;
		o_spi_sdi = 1'b0;
	end
	// Read data is taken at the edge that raises sclk, well after it settled.
	task automatic bit_io(input logic b, output logic s);
		o_spi_sdi <= b;
		repeat (6) @(posedge i_clk_sys);
		s = i_spi_sdo;
		o_spi_sclk <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		o_spi_sclk <= 1'b0;
	endtask
	task automatic xfer(input logic rd, input logic [14:0] a, input int n,
		inout logic [7:0] d [4]);
		logic s;
		o_spi_cs_n <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
		for (int i = 15; i >= 0; i--) bit_io(i == 15 ? rd : a[i], s);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_io(d[k][i], s);
				d[k][i] = s;
			end
		end
		repeat (6) @(posedge i_clk_sys);
		o_spi_cs_n <= 1'b1;
		// A released data line must not keep showing the last bit.
		o_spi_sdi <= ~o_spi_sdi;
		repeat (8) @(posedge i_clk_sys);
	endtask
endmodule // spi_host

/* test_converter_id_spi_regs.sv */
// Self-checking bench of the serial register bank.
// Assumes the host model in spi_host drives every serial frame.
module test_converter_id_spi_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [15:0] PART_ID = 16'h5A3C; // Value is arbitrary.
	localparam [7:0]  VERSION = 8'h3C;    // Value is arbitrary.
	localparam [15:0] MAKER   = 16'h7E21; // Value is arbitrary.
	reg         i_clk_sys;
	reg         i_rst_n;
	reg  [23:0] pos;
	reg         tick;
	wire        sclk;
	wire        cs_n;
	wire        sdi;
	wire        sdo;
	wire        sdo_oe;
	wire        sdo_line;
	wire [7:0]  clk_a;
	wire [7:0]  clk_b;
	wire [15:0] fs_a;
	wire [15:0] fs_b;
	int         errors;
	int         n_compared;
	logic [7:0] d [4];
	assign sdo_line = sdo_oe ? sdo : tick;
	converter_id_spi_regs #(.PART_IDENTITY(PART_ID),
		.SILICON_VERSION(VERSION), .MAKER_IDENTITY(MAKER)) i_dut (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_spi_sclk(sclk),
		.i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
		.o_spi_sdo_oe(sdo_oe), .i_alignment_edge_position(pos),
		.o_clock_control_a(clk_a), .o_clock_control_b(clk_b),
		.o_input_a_full_scale(fs_a), .o_input_b_full_scale(fs_b),
		.o_reference_bypass(), .o_timestamp_input_control());
	spi_host i_host (.i_clk_sys(i_clk_sys), .i_spi_sdo(sdo_line),
		.o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_spi_sdi(sdi));
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) tick <= ~tick;
	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done;
		if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_reset;
		check("fs_a", 24'h00A000, {8'h00, fs_a});
		check("fs_b", 24'h00A000, {8'h00, fs_b});
		i_host.xfer(1'b1, 15'h0010, 1, d);
		check("uic", 24'h000000, {16'h0000, d[0]});
	endtask
	task automatic t_ident;
		i_host.xfer(1'b1, 15'h0004, 3, d);
		check("part_id", {8'h00, PART_ID}, {8'h00, d[1], d[0]});
		check("version", {16'h0000, VERSION}, {16'h0000, d[2]});
		i_host.xfer(1'b1, 15'h000C, 2, d);
		check("maker_id", {8'h00, MAKER}, {8'h00, d[1], d[0]});
	endtask
	task automatic t_ro_write;
		d = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
		i_host.xfer(1'b0, 15'h0004, 3, d);
		d = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
		i_host.xfer(1'b0, 15'h000C, 2, d);
		t_ident;
	endtask
	task automatic t_stream;
		d = '{8'h12, 8'h34, 8'h00, 8'h00};
		i_host.xfer(1'b0, 15'h0030, 2, d);
		check("fs_a_up", 24'h003412, {8'h00, fs_a});
		d = '{8'h00, 8'h00, 8'h00, 8'h00};
		i_host.xfer(1'b0, 15'h0000, 1, d);
		d = '{8'h56, 8'h78, 8'h00, 8'h00};
		i_host.xfer(1'b0, 15'h0033, 2, d);
		check("fs_b_down", 24'h005678, {8'h00, fs_b});
		d = '{8'h20, 8'h00, 8'h00, 8'h00};
		i_host.xfer(1'b0, 15'h0000, 1, d);
		i_host.xfer(1'b1, 15'h0030, 2, d);
		check("fs_a_read", 24'h003412, {8'h00, d[1], d[0]});
	endtask
	task automatic t_hold;
		d = '{8'h01, 8'h00, 8'h00, 8'h00};
		i_host.xfer(1'b0, 15'h0010, 1, d);
		d = '{8'h11, 8'h22, 8'h33, 8'h00};
		i_host.xfer(1'b0, 15'h0029, 3, d);
		check("clk_a_hold", 24'h000033, {16'h0000, clk_a});
		check("clk_b_hold", 24'h000020, {16'h0000, clk_b});
		d = '{8'h00, 8'h00, 8'h00, 8'h00};
		i_host.xfer(1'b0, 15'h0010, 1, d);
	endtask
	task automatic t_position;
		pos <= 24'hC3B2A1;
		repeat (4) @(posedge i_clk_sys);
		i_host.xfer(1'b1, 15'h002C, 3, d);
		check("position", 24'hC3B2A1, {d[2], d[1], d[0]});
	endtask
	initial begin
		errors = 0;
		n_compared = 0;
		tick = 1'b0;
		pos = 24'h000000;
		i_rst_n = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(posedge i_clk_sys);
		t_reset;
		t_ident;
		t_ro_write;
		t_stream;
		t_hold;
		t_position;
		test_done;
	end
	// A hung frame must still end the run with a verdict.
	initial begin
		repeat (60000) @(posedge i_clk_sys);
		errors++;
		$display("MISMATCH run_length expected end seen timeout");
		test_done;
	end
endmodule // test_converter_id_spi_regs
